// ---- verilog/mpf_filter.sv ----
// Receive pause handling and destination address filter with an AXI4-Lite register slave.
// Notes on behaviour
// - Pause frame needs slot 1 or reserved address, type 8808, opcode 0001.
// - Valid pause frame overwrites pause time regardless of old value or enable.
// - Pause frame receipt raises event 12, in half duplex too.
// - Pause enable and non-zero pause time hold off new transmit frames.
// - Pause time loads only in full duplex.
// - Errored pause frames are discarded; valid ones bump the pause statistic.
// - Pause time decrements every 128 receive clocks once transmit stops.
// - Retry-test bit makes it decrement every receive clock.
// - With pause enable clear, decrement regardless of transmit state.
// - Reaching zero by decrement raises event 13.
// - Too long or receive error flags frame bad at once; end reports good/bad.
// - Receiver pulses alignment, FCS, short, long, jabber, symbol, length statistics.
// - Jumbo enable, clear at reset, allows 10240 bytes; longer is discarded.
// - Source address ignored; half-duplex transmit at address time blocks copy.
// - Destination is first six bytes, LSB first; bit 0 marks multicast.
// - Four address slots, bottom holds first four bytes, top last two.
// - Slot deactivates on reset or bottom write, activates on top write.
// - Six-bit hash index bit i XORs address bits i, i+6 up to i+42.
// - Hash vector low half in bottom register, high half in top.
// - Hash match needs set bit and matching multicast or unicast enable.
// - Copy-all copies error-free frames only.
// - Configuration bit 19 copies frames with FCS errors too.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module mpf_filter (
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              rx_clk_i,
	input  wire logic              rx_dv_i,
	input  wire logic [3:0]        rx_data_i,
	input  wire logic              receive_error_in_i,
	input  wire logic              tx_busy_i,
	output logic                   tx_hold_o,
	output logic                   pause_rx_evt_o,
	output logic                   pause_zero_evt_o,
	output mpf_pkg::mpf_stat_s     stat_inc_o,
	output mpf_pkg::mpf_dma_s      dma_o
);
	import mpf_pkg::*;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hEDB8_8320) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [5:0] hash_idx(input logic [47:0] a);
		logic [5:0] h;
		h = 6'h00;
		for (int k = 0; k < 8; k++) begin
			h = h ^ a[k*6 +: 6];
		end
		return h;
	endfunction

	// ==========================================================================
	// Registers
	// ==========================================================================
	logic [31:0] ncfg_r;
	logic [31:0] hash_lo_r;
	logic [31:0] hash_hi_r;
	logic [31:0] sa_lo_r [4];
	logic [15:0] sa_hi_r [4];
	logic [3:0]  sa_act_r;
	logic [31:0] frame_type_compare_r;
	logic [15:0] ptime_r;
	logic [6:0]  quanta_r;

	// ==========================================================================
	// AXI4-Lite slave
	// ==========================================================================
	logic        aw_full_r;
	logic        w_full_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	wire         wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
	wire  [7:0]  wa = aw_addr_r;
	wire         wa_sa = (wa >= MPF_A_SA1L) && (wa <= MPF_A_SA4H);
	wire  [1:0]  wa_slot = 2'(({24'h0, wa} - {24'h0, MPF_A_SA1L}) >> 3);
	wire         wa_ok = (wa == MPF_A_NCFG) || (wa == MPF_A_HASHL) || (wa == MPF_A_HASHH)
				|| wa_sa || (wa == MPF_A_TYPE) || (wa == MPF_A_PTIME);
	wire  [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	wire         ra_sa = (s_axi_araddr >= MPF_A_SA1L) && (s_axi_araddr <= MPF_A_SA4H);
	wire  [1:0]  ra_slot = 2'(({24'h0, s_axi_araddr} - {24'h0, MPF_A_SA1L}) >> 3);
	logic [31:0] rd_val;
	logic        rd_ok;

	assign s_axi_awready = ~aw_full_r;
	assign s_axi_wready  = ~w_full_r;
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		if (ra_sa) begin
			rd_val = s_axi_araddr[2] ? {16'h0000, sa_hi_r[ra_slot]} : sa_lo_r[ra_slot];
		end else begin
			unique case (s_axi_araddr)
				MPF_A_NCFG:  rd_val = ncfg_r;
				MPF_A_HASHL: rd_val = hash_lo_r;
				MPF_A_HASHH: rd_val = hash_hi_r;
				MPF_A_TYPE:  rd_val = frame_type_compare_r;
				MPF_A_PTIME: rd_val = {16'h0000, ptime_r};
				default:     rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_full_r    <= 1'b0;
			w_full_r     <= 1'b0;
			aw_addr_r    <= 8'h00;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'b00;
			s_axi_rdata  <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && !aw_full_r) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wa_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ncfg_r    <= MPF_NCFG_RST;
			hash_lo_r <= 32'h0000_0000;
			hash_hi_r <= 32'h0000_0000;
			frame_type_compare_r <= 32'h0000_0000;
			sa_act_r  <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				sa_lo_r[i] <= 32'h0000_0000;
				sa_hi_r[i] <= 16'h0000;
			end
		end else if (wr_go) begin
			if (wa == MPF_A_NCFG) ncfg_r <= (ncfg_r & ~wmask) | (w_data_r & wmask);
			if (wa == MPF_A_HASHL) hash_lo_r <= (hash_lo_r & ~wmask) | (w_data_r & wmask);
			if (wa == MPF_A_HASHH) hash_hi_r <= (hash_hi_r & ~wmask) | (w_data_r & wmask);
			if (wa == MPF_A_TYPE) frame_type_compare_r <= (frame_type_compare_r & ~wmask) | (w_data_r & wmask);
			if (wa_sa && !wa[2]) begin
				sa_lo_r[wa_slot]  <= (sa_lo_r[wa_slot] & ~wmask) | (w_data_r & wmask);
				sa_act_r[wa_slot] <= 1'b0;
			end
			if (wa_sa && wa[2]) begin
				sa_hi_r[wa_slot]  <= (sa_hi_r[wa_slot] & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
				sa_act_r[wa_slot] <= 1'b1;
			end
		end
	end

	wire cfg_fd   = ncfg_r[MPF_B_FD];
	wire cfg_pae  = ncfg_r[MPF_B_PAE];
	wire cfg_rty  = ncfg_r[MPF_B_RTY];

	// ==========================================================================
	// Receive clock and pin synchronisers
	// ==========================================================================
	logic [2:0] rxc_r;
	logic [5:0] rxd_s1_r;
	logic [5:0] rxd_s2_r;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rxc_r    <= 3'b000;
			rxd_s1_r <= 6'h00;
			rxd_s2_r <= 6'h00;
		end else begin
			rxc_r    <= {rxc_r[1:0], rx_clk_i};
			rxd_s1_r <= {receive_error_in_i, rx_dv_i, rx_data_i};
			rxd_s2_r <= rxd_s1_r;
		end
	end
	// Sampling on the falling edge keeps clear of the data changing near the rising edge.
	wire        rx_fall = rxc_r[2] & ~rxc_r[1];
	wire        rx_rise = rxc_r[1] & ~rxc_r[2];
	wire [3:0]  nib = rxd_s2_r[3:0];
	wire        dv  = rxd_s2_r[4];
	wire        er  = rxd_s2_r[5];

	// ==========================================================================
	// Frame reception
	// ==========================================================================
	typedef enum logic [2:0] {
		MPF_ST_IDLE = 3'b001,
		MPF_ST_PRE  = 3'b010,
		MPF_ST_DATA = 3'b100
	} mpf_st_e;
	mpf_st_e     st_r;
	logic        hi_r;
	logic [3:0]  lo_r;
	logic [13:0] cnt_r;
	logic [31:0] crc_r;
	logic [47:0] da_r;
	logic [15:0] ltype_r;
	logic [15:0] opc_r;
	logic [15:0] pq_r;
	logic        bad_r;
	logic        er_r;
	logic        long_r;
	logic        hdblk_r;

	wire [13:0] max_len = ncfg_r[MPF_B_JUMBO] ? MPF_JUMBO_LEN : MPF_MAX_LEN;
	wire [7:0]  byte_in = {nib, lo_r};
	wire        byte_st = (st_r == MPF_ST_DATA) && rx_fall && dv && hi_r;
	wire        end_st  = (st_r == MPF_ST_DATA) && rx_fall && !dv;
	wire        too_long = byte_st && (cnt_r == max_len);
	wire        err_now  = rx_fall && dv && er && (st_r == MPF_ST_DATA);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r    <= MPF_ST_IDLE;
			hi_r    <= 1'b0;
			lo_r    <= 4'h0;
			cnt_r   <= 14'd0;
			crc_r   <= 32'hFFFF_FFFF;
			da_r    <= 48'h0;
			ltype_r <= 16'h0000;
			opc_r   <= 16'h0000;
			pq_r    <= 16'h0000;
			bad_r   <= 1'b0;
			er_r    <= 1'b0;
			long_r  <= 1'b0;
			hdblk_r <= 1'b0;
		end else begin
			unique case (st_r)
				MPF_ST_IDLE: begin
					if (rx_fall && dv && nib == MPF_NIB_PRE) st_r <= MPF_ST_PRE;
				end
				MPF_ST_PRE: begin
					if (rx_fall && !dv) begin
						st_r <= MPF_ST_IDLE;
					end else if (rx_fall && nib == MPF_NIB_SFD) begin
						st_r   <= MPF_ST_DATA;
						hi_r   <= 1'b0;
						cnt_r  <= 14'd0;
						crc_r  <= 32'hFFFF_FFFF;
						bad_r  <= 1'b0;
						er_r   <= 1'b0;
						long_r <= 1'b0;
						hdblk_r <= 1'b0;
					end else if (rx_fall && nib != MPF_NIB_PRE) begin
						st_r <= MPF_ST_IDLE;
					end
				end
				MPF_ST_DATA: begin
					if (end_st) st_r <= MPF_ST_IDLE;
					if (rx_fall && dv) begin
						hi_r <= ~hi_r;
						if (!hi_r) lo_r <= nib;
					end
					if (byte_st) begin
						crc_r <= crc_byte(crc_r, byte_in);
						if (cnt_r != max_len) cnt_r <= cnt_r + 14'd1;
						if (cnt_r < 14'd6) da_r[cnt_r[2:0]*8 +: 8] <= byte_in;
						// Of the two addresses only the destination is latched; the source bytes pass unchecked.
						if (cnt_r == 14'd5) begin
							hdblk_r <= tx_busy_i && !cfg_fd && !ncfg_r[MPF_B_RXHD];
						end
						if (cnt_r == 14'd12) ltype_r[15:8] <= byte_in;
						if (cnt_r == 14'd13) ltype_r[7:0]  <= byte_in;
						if (cnt_r == 14'd14) opc_r[15:8]   <= byte_in;
						if (cnt_r == 14'd15) opc_r[7:0]    <= byte_in;
						if (cnt_r == 14'd16) pq_r[15:8]    <= byte_in;
						if (cnt_r == 14'd17) pq_r[7:0]     <= byte_in;
					end
					if (too_long) long_r <= 1'b1;
					if (err_now) er_r <= 1'b1;
					if (too_long || err_now) bad_r <= 1'b1;
				end
				default: st_r <= MPF_ST_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// End-of-frame checks and filter
	// ==========================================================================
	wire        e_fcs   = (crc_r != MPF_CRC_RES);
	wire        e_align = hi_r;
	wire        e_short = (cnt_r < MPF_MIN_LEN);
	wire        e_hard  = long_r | er_r | e_short | e_align;
	wire        e_fcs_drop = e_fcs & ~ncfg_r[MPF_B_IFCS];
	wire        is_mc   = da_r[0];
	wire [5:0]  hidx    = hash_idx(da_r);
	wire [63:0] hvec    = {hash_hi_r, hash_lo_r};
	wire        h_hit   = hvec[hidx] &&
				((is_mc && ncfg_r[MPF_B_MCH]) || (!is_mc && ncfg_r[MPF_B_UCH]));
	logic [3:0] sa_hit;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sa_hit[i] = sa_act_r[i] && (da_r == {sa_hi_r[i], sa_lo_r[i]});
		end
	end
	wire        f_hit   = |sa_hit || h_hit || ncfg_r[MPF_B_CAF];
	wire        good    = !e_hard && !e_fcs_drop;
	wire        do_copy = good && f_hit && !hdblk_r;
	wire        pause_ok = end_st && !e_hard && !e_fcs &&
				(sa_hit[0] || da_r == MPF_PAUSE_DA) &&
				ltype_r == MPF_TYPE_CTL && opc_r == MPF_OPC_PAUSE;
	wire        len_mis = (ltype_r < MPF_LEN_TYPE) && ({ltype_r[13:0]} + MPF_LEN_OVH != cnt_r);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			dma_o      <= '0;
			stat_inc_o <= '0;
			pause_rx_evt_o <= 1'b0;
		end else begin
			dma_o.byte_vld <= byte_st && !bad_r && !too_long && !err_now;
			dma_o.data     <= byte_in;
			dma_o.bad      <= (too_long && !bad_r) || (err_now && !bad_r);
			dma_o.done     <= end_st;
			dma_o.good     <= end_st && good;
			dma_o.copy     <= end_st && do_copy;
			stat_inc_o.pause_rx <= pause_ok;
			stat_inc_o.align    <= end_st && e_align;
			stat_inc_o.fcs      <= end_st && e_fcs && !e_align;
			stat_inc_o.short_f  <= end_st && e_short;
			stat_inc_o.long_f   <= end_st && long_r && !e_fcs;
			stat_inc_o.jabber   <= end_st && long_r && e_fcs;
			stat_inc_o.symbol   <= end_st && er_r;
			stat_inc_o.len_mis  <= end_st && !e_short && len_mis;
			pause_rx_evt_o      <= pause_ok;
		end
	end

	// ==========================================================================
	// Pause timer
	// ==========================================================================
	wire dec_ok   = !cfg_pae || !tx_busy_i;
	wire dec_tick = rx_rise && dec_ok && (cfg_rty || quanta_r == MPF_QUANTA_LAST);
	wire do_load  = pause_ok && cfg_fd;
	assign tx_hold_o = cfg_pae && (ptime_r != 16'h0000);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ptime_r  <= 16'h0000;
			quanta_r <= 7'd0;
			pause_zero_evt_o <= 1'b0;
		end else begin
			pause_zero_evt_o <= 1'b0;
			if (rx_rise && dec_ok) quanta_r <= quanta_r + 7'd1;
			if (do_load) begin
				ptime_r  <= pq_r;
				quanta_r <= 7'd0;
			end else if (dec_tick && ptime_r != 16'h0000) begin
				ptime_r <= ptime_r - 16'h0001;
				pause_zero_evt_o <= (ptime_r == 16'h0001);
			end
		end
	end
endmodule // mpf_filter

// ---- pkg/mpf_pkg.sv ----
// Constants and carrier types for the pause and receive address filter block.
package mpf_pkg;
	// ==========================================================================
	// Register map, byte addresses
	// ==========================================================================
	localparam logic [7:0] MPF_A_NCFG  = 8'h04;
	localparam logic [7:0] MPF_A_PTIME = 8'h38;
	localparam logic [7:0] MPF_A_HASHL = 8'h90;
	localparam logic [7:0] MPF_A_HASHH = 8'h94;
	localparam logic [7:0] MPF_A_SA1L  = 8'h98;
	localparam logic [7:0] MPF_A_SA1H  = 8'h9C;
	localparam logic [7:0] MPF_A_SA4H  = 8'hB4;
	localparam logic [7:0] MPF_A_TYPE  = 8'hB8;
	localparam logic [31:0] MPF_NCFG_RST = 32'h0000_0000;
	// ==========================================================================
	// Configuration bit positions
	// ==========================================================================
	localparam int MPF_B_FD   = 1;
	localparam int MPF_B_JUMBO = 3;
	localparam int MPF_B_CAF  = 4;
	localparam int MPF_B_MCH  = 6;
	localparam int MPF_B_UCH  = 7;
	localparam int MPF_B_RTY  = 12;
	localparam int MPF_B_PAE  = 13;
	localparam int MPF_B_RXHD = 18;
	localparam int MPF_B_IFCS = 19;
	// ==========================================================================
	// Frame constants
	// ==========================================================================
	// First received byte sits in the low byte, as in the address registers.
	localparam logic [47:0] MPF_PAUSE_DA  = 48'h0100_00C2_8001;
	localparam logic [15:0] MPF_TYPE_CTL  = 16'h8808;
	localparam logic [15:0] MPF_OPC_PAUSE = 16'h0001;
	localparam logic [15:0] MPF_LEN_TYPE  = 16'h0600;
	localparam logic [13:0] MPF_LEN_OVH   = 14'd18;
	localparam logic [31:0] MPF_CRC_RES   = 32'hDEBB_20E3;
	localparam logic [3:0]  MPF_NIB_PRE   = 4'h5;
	localparam logic [3:0]  MPF_NIB_SFD   = 4'hD;
	localparam logic [13:0] MPF_MIN_LEN   = 14'd64;
	localparam logic [13:0] MPF_MAX_LEN   = 14'd1518;
	localparam logic [13:0] MPF_JUMBO_LEN = 14'd10240;
	localparam int MPF_QUANTA_BITS = 512;
	localparam int MPF_NIBBLE_BITS = 4;
	localparam logic [6:0] MPF_QUANTA_LAST = 7'(MPF_QUANTA_BITS / MPF_NIBBLE_BITS - 1);
	// ==========================================================================
	// Carriers
	// ==========================================================================
	typedef struct packed {
		logic pause_rx;
		logic align;
		logic fcs;
		logic short_f;
		logic long_f;
		logic jabber;
		logic symbol;
		logic len_mis;
	} mpf_stat_s;
	typedef struct packed {
		logic       bad;
		logic       done;
		logic       good;
		logic       copy;
		logic       byte_vld;
		logic [7:0] data;
	} mpf_dma_s;
endpackage

// ---- verif/mpf_phy_model.sv ----
// Behavioural link partner that sends nibble frames into the receive port.
`timescale 1ns/1ns
module mpf_phy_model (
	output logic       rx_clk_o,
	output logic       rx_dv_o,
	output logic [3:0] rx_data_o,
	output logic       rx_err_o
);
	import mpf_pkg::*;
	logic busy;
	// ==========
	// Clock and idle
	// ==========
	// The receive clock runs free, so pause quanta keep counting between frames.
	initial begin
		rx_clk_o = 1'b0;
		rx_dv_o = 1'b0;
		rx_data_o = 4'h0;
		rx_err_o = 1'b0;
		busy = 1'b0;
		forever begin
			#62 rx_clk_o = 1'b1;
			#63 rx_clk_o = 1'b0;
		end
	end
	// Idle data toggles so a receiver that ignores the valid line sees garbage.
	always @(posedge rx_clk_o) if (!busy) rx_data_o <= ~rx_data_o;
	// Appends the frame check word, inverted in bit 0 when bad[0] is set.
	// Setting bad[1] raises the receive error line during byte 20.
	task automatic send(input logic [7:0] b[$], input logic [1:0] bad);
		logic [31:0] c;
		logic [7:0]  q[$];
		c = 32'hFFFF_FFFF;
		q = b;
		foreach (b[i]) for (int k = 0; k < 8; k++)
			c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
		c = ~c ^ {31'h0, bad[0]};
		for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
		@(negedge rx_clk_o);
		busy = 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge rx_clk_o);
			rx_dv_o <= 1'b1;
			rx_data_o <= (i == 15) ? MPF_NIB_SFD : MPF_NIB_PRE;
		end
		foreach (q[i]) for (int h = 0; h < 2; h++) begin
			@(posedge rx_clk_o);
			rx_data_o <= q[i][4*h +: 4];
			rx_err_o <= bad[1] && i == 20;
		end
		@(posedge rx_clk_o);
		rx_dv_o <= 1'b0;
		repeat (24) @(posedge rx_clk_o);
		@(negedge rx_clk_o);
		busy = 1'b0;
	endtask
endmodule // mpf_phy_model

// ---- verif/mpf_assertions.sv ----
// Port checks for the pause and receive address filter block.
`timescale 1ns/1ns
module mpf_assertions (
	input wire logic               mclk_i,
	input wire logic               rst_i,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic               tx_hold_o,
	input wire logic               pause_rx_evt_o,
	input wire logic               pause_zero_evt_o,
	input wire mpf_pkg::mpf_stat_s stat_inc_o,
	input wire mpf_pkg::mpf_dma_s  dma_o
);
	import mpf_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// Properties
	// ==========
	chk_pause_stat: assert property (pause_rx_evt_o |-> stat_inc_o.pause_rx)
		else $error("pause event without statistic");
	chk_pause_good: assert property (
		pause_rx_evt_o |-> dma_o.done && dma_o.good && !stat_inc_o.fcs)
		else $error("pause event on a bad frame");
	chk_pause_once: assert property (pause_rx_evt_o |=> !pause_rx_evt_o [*4])
		else $error("pause event longer than one pulse");
	chk_zero_hold: assert property (pause_zero_evt_o |-> !tx_hold_o)
		else $error("zero event while hold stands");
	chk_zero_once: assert property (pause_zero_evt_o |=> !pause_zero_evt_o [*3])
		else $error("zero event repeated");
	chk_copy_done: assert property (
		dma_o.copy |-> dma_o.done && !stat_inc_o.short_f)
		else $error("copy outside frame end or on short frame");
	chk_short_bad: assert property (dma_o.done && stat_inc_o.short_f |-> !dma_o.good)
		else $error("short frame reported good");
	chk_byte_gap: assert property (dma_o.byte_vld |=> !dma_o.byte_vld [*8])
		else $error("bytes closer than two nibbles");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	cover property (pause_rx_evt_o);
	cover property (pause_zero_evt_o);
	cover property (dma_o.copy);
endmodule // mpf_assertions
bind mpf_filter mpf_assertions mpf_assertions_i (.mclk_i, .rst_i, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .tx_hold_o, .pause_rx_evt_o, .pause_zero_evt_o,
	.stat_inc_o, .dma_o);

// ---- verif/tb_mpf_filter.sv ----
// Self-checking bench for the pause and receive address filter block.
`timescale 1ns/1ns
module tb_mpf_filter;
	import mpf_pkg::*;
	localparam logic [31:0] FD = 32'h1 << MPF_B_FD;
	localparam logic [31:0] CAF = 32'h1 << MPF_B_CAF;
	localparam logic [31:0] MCH = 32'h1 << MPF_B_MCH;
	localparam logic [31:0] UCH = 32'h1 << MPF_B_UCH;
	localparam logic [31:0] RTY = 32'h1 << MPF_B_RTY;
	localparam logic [31:0] PAE = 32'h1 << MPF_B_PAE;
	localparam logic [31:0] RXHD = 32'h1 << MPF_B_RXHD;
	localparam logic [31:0] IFCS = 32'h1 << MPF_B_IFCS;
	localparam logic [47:0] DA_U = 48'h5566_7788_9902;
	localparam logic [47:0] DA_M = 48'h5566_7788_9903;
	logic        mclk_i, rst_i, tx_busy_i, rx_clk, rx_dv, rx_err;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, tx_hold_o, pause_rx_evt_o, pause_zero_evt_o;
	logic [3:0]  rx_dat;
	mpf_stat_s   stat_inc_o;
	mpf_dma_s    dma_o;
	int          cnt[8], base[8], n_errors, cmp_count, n;
	logic [7:0]  fq[$];
	logic [63:0] hv;
	mpf_filter mpf_filter_i (.mclk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_clk_i(rx_clk),
		.rx_dv_i(rx_dv), .rx_data_i(rx_dat), .receive_error_in_i(rx_err), .tx_busy_i,
		.tx_hold_o, .pause_rx_evt_o, .pause_zero_evt_o, .stat_inc_o, .dma_o);
	mpf_phy_model mpf_phy_model_i (.rx_clk_o(rx_clk), .rx_dv_o(rx_dv), .rx_data_o(rx_dat),
		.rx_err_o(rx_err));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// Pulses are counted, so a scenario compares counts before and after a frame.
	always @(posedge mclk_i) begin
		cnt[0] += (pause_rx_evt_o === 1'b1);
		cnt[1] += (pause_zero_evt_o === 1'b1);
		cnt[2] += (dma_o.copy === 1'b1);
		cnt[3] += (dma_o.done === 1'b1);
		cnt[4] += (stat_inc_o.fcs === 1'b1);
		cnt[5] += (stat_inc_o.short_f === 1'b1);
		cnt[6] += (stat_inc_o.pause_rx === 1'b1);
		cnt[7] += (dma_o.bad === 1'b1);
	end
	// ==========
	// Shared tasks
	// ==========
	function int dl(int i);
		return cnt[i] - base[i];
	endfunction
	function automatic logic [5:0] hidx(logic [47:0] d);
		logic [5:0] h;
		h = 6'h0;
		for (int i = 0; i < 48; i++) h[i % 6] ^= d[i];
		return h;
	endfunction
	task check(input logic [63:0] s, input logic [63:0] e, input string m);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge mclk_i);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge mclk_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) begin
			check(0, 1, "write hang");
			close_out();
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge mclk_i);
			ta = s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk_i);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			check(0, 1, "read hang");
			close_out();
		end
		check(d, e, "read data");
		check({30'h0, r}, {30'h0, er}, "read response");
	endtask
	task frame(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] pt,
		input int len, input logic [1:0] bad);
		fq = {};
		for (int i = 0; i < 6; i++) fq.push_back(da[8*i +: 8]);
		for (int i = 0; i < 6; i++) fq.push_back(8'h02);
		fq = {fq, ty[15:8], ty[7:0], MPF_OPC_PAUSE[15:8], MPF_OPC_PAUSE[7:0], pt[15:8], pt[7:0]};
		while (fq.size() < len) fq.push_back(8'h00);
		base = cnt;
		mpf_phy_model_i.send(fq, bad);
		check(dl(3), 1, "frame end");
	endtask
	// ==========
	// Scenarios
	// ==========
	task t_regs;
		rd(MPF_A_NCFG, MPF_NCFG_RST, 2'b00);
		rd(8'hFC, 32'h0, 2'b10);
		axi_wr(MPF_A_SA1L, 32'h8765_4321);
		axi_wr(MPF_A_SA1H, 32'h0000_CBA9);
		rd(MPF_A_SA1H, 32'h0000_CBA9, 2'b00);
		$display("test regs done");
	endtask
	task t_slot;
		axi_wr(MPF_A_NCFG, FD);
		frame(48'hCBA9_8765_4321, 16'h0800, 16'h0, 60, 1'b0);
		check(dl(2), 1, "slot copy");
		axi_wr(MPF_A_SA1L, 32'h8765_4321);
		frame(48'hCBA9_8765_4321, 16'h0800, 16'h0, 60, 1'b0);
		check(dl(2), 0, "inactive slot copy");
		$display("test slot done");
	endtask
	task t_hash;
		hv = (64'h1 << hidx(DA_U)) | (64'h1 << hidx(DA_M));
		axi_wr(MPF_A_HASHL, hv[31:0]);
		axi_wr(MPF_A_HASHH, hv[63:32]);
		for (int i = 0; i < 4; i++) begin
			axi_wr(MPF_A_NCFG, FD | ((i < 2) ? UCH : MCH));
			frame(i[0] ? DA_M : DA_U, 16'h0800, 16'h0, 60, 1'b0);
			check(dl(2), (i == 0 || i == 3), "hash copy");
		end
		$display("test hash done");
	endtask
	task t_copy;
		axi_wr(MPF_A_NCFG, FD | CAF);
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 60, 1'b0);
		check(dl(2), 1, "copy all");
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 20, 1'b0);
		check({dl(2), dl(5)}, {32'd0, 32'd1}, "short frame");
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 60, 1'b1);
		check({dl(2), dl(4)}, {32'd0, 32'd1}, "fcs frame");
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 60, 2'b10);
		check({dl(2), dl(7)}, {32'd0, 32'd1}, "error frame");
		axi_wr(MPF_A_NCFG, FD | CAF | IFCS);
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 60, 1'b1);
		check(dl(2), 1, "fcs frame kept");
		axi_wr(MPF_A_NCFG, CAF);
		tx_busy_i <= 1'b1;
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 60, 1'b0);
		check(dl(2), 0, "half duplex busy");
		axi_wr(MPF_A_NCFG, CAF | RXHD);
		frame(48'h0000_0000_2202, 16'h0800, 16'h0, 60, 1'b0);
		check(dl(2), 1, "half duplex allowed");
		$display("test copy done");
	endtask
	task t_pause;
		axi_wr(MPF_A_NCFG, FD | PAE);
		frame(MPF_PAUSE_DA, MPF_TYPE_CTL, 16'h0001, 60, 1'b0);
		check({dl(0), dl(6)}, {32'd1, 32'd1}, "pause event");
		check(tx_hold_o, 1, "hold");
		rd(MPF_A_PTIME, 32'h1, 2'b00);
		@(posedge mclk_i);
		tx_busy_i <= 1'b0;
		for (n = 0; n < 2500 && dl(1) == 0; n++) @(posedge mclk_i);
		check(n > 1200 && n < 2500, 1, "quantum time");
		check(tx_hold_o, 0, "hold off");
		axi_wr(MPF_A_NCFG, PAE);
		frame(MPF_PAUSE_DA, MPF_TYPE_CTL, 16'h0005, 60, 1'b0);
		check(dl(0), 1, "half duplex event");
		rd(MPF_A_PTIME, 32'h0, 2'b00);
		tx_busy_i <= 1'b1;
		axi_wr(MPF_A_NCFG, FD | RTY);
		frame(MPF_PAUSE_DA, MPF_TYPE_CTL, 16'h0004, 60, 1'b1);
		check(dl(0), 0, "errored pause");
		frame(MPF_PAUSE_DA, MPF_TYPE_CTL, 16'h0004, 60, 1'b0);
		check({dl(0), dl(1)}, {32'd1, 32'd1}, "fast countdown");
		$display("test pause done");
	endtask
	initial begin
		n_errors = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		tx_busy_i = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_regs();
		t_slot();
		t_hash();
		t_copy();
		t_pause();
		close_out();
	end
	initial begin
		#1_000_000;
		check(0, 1, "run timeout");
		close_out();
	end
endmodule // tb_mpf_filter
